// file: bench/four_level_page_walker_test.sv
`timescale 1ns/1ps
module four_level_page_walker_test;
	import pw_walker_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, paging_enable = 1'b0, address_extension_enable = 1'b1;
	logic long_mode_enable = 1'b1, no_exec_enable = 1'b0, context_tag_enable = 1'b0;
	logic root_wr_en = 1'b0, req_valid = 1'b0, mem_rd_req, mem_rd_valid, req_ready, done;
	logic [63:0] root_wr_data = 64'h0, root_rd_data, mem_rd_data;
	logic [11:0] context_tag;
	pw_req_t req = '0;
	pw_rsp_t rsp;
	logic [51:0] mem_rd_addr;
	logic [1:0] mem_rd_attr, top_attr;
	logic [3:0] lat = 4'h1;
	logic [7:0] reads, r0;
	int bad_count = 0, checked = 0, cyc = 0;
	logic [51:0] a [4] = '{52'h1008, 52'h2010, 52'h3018, 52'h4020};
	logic [63:0] g [4] = '{64'h2007, 64'h3007, 64'h4007, 64'h5007};
	int fi [6] = '{0, 0, 1, 2, 3, 3};
	logic [63:0] fv [6] = '{64'h2006, 64'h2087, 64'h4000_2087, 64'h0060_2087,
		64'h2000_0000_5007, 64'h8000_0000_5007};
	pw_walker #(.PA_W(40), .GB_PAGES(1'b1)) i_dut (.clk(clk), .sys_rst(sys_rst),
		.paging_enable(paging_enable), .address_extension_enable(address_extension_enable),
		.long_mode_enable(long_mode_enable), .no_exec_enable(no_exec_enable),
		.context_tag_enable(context_tag_enable), .root_wr_en(root_wr_en),
		.root_wr_data(root_wr_data), .root_rd_data(root_rd_data), .context_tag(context_tag),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done), .rsp(rsp),
		.mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_attr(mem_rd_attr),
		.mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));
	pw_mem_model i_mem (.clk(clk), .sys_rst(sys_rst), .mem_rd_req(mem_rd_req),
		.mem_rd_addr(mem_rd_addr), .lat(lat), .mem_rd_valid(mem_rd_valid),
		.mem_rd_data(mem_rd_data), .reads(reads));
	initial begin
		forever #50 clk = ~clk;
	end
	task final_report();
		if (bad_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report
	task check(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task set_root(input logic [63:0] v);
		root_wr_en = 1'b1;
		root_wr_data = v;
		@(negedge clk);
		root_wr_en = 1'b0;
		repeat (2) @(negedge clk);
	endtask : set_root
	// Fault answers only promise the fault flag and a zero address.
	task walk(input logic [51:0] ep, input logic ef, input logic et, input logic eok);
		int n;
		n = 0;
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		top_attr = mem_rd_attr;
		while (done !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		check({rsp.fault, rsp.phys}, {ef, ep});
		if (!ef) check({rsp.translated, rsp.rights_ok}, {et, eok});
		@(negedge clk);
	endtask : walk
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
		context_tag_enable = 1'b1;
		set_root(64'h1018);
		check(context_tag, 12'h018);
		check(root_rd_data, 64'h1018);
		context_tag_enable = 1'b0;
		repeat (2) @(negedge clk);
		check(context_tag, 12'h000);
		for (int i = 0; i < 4; i++) i_mem.tbl[a[i]] = g[i];
		req.lin = 48'h8000_0000_1234;
		walk(52'h1234, 1'b0, 1'b0, 1'b1);
		paging_enable = 1'b1;
		req = {9'd1, 9'd2, 9'd3, 9'd4, 12'habc, 3'b100};
		r0 = reads;
		walk(52'h5abc, 1'b0, 1'b1, 1'b1);
		check(top_attr, 2'b11);
		check(reads - r0, 8'h04);
		lat = 4'h5;
		req.is_user = 1'b1;
		i_mem.tbl[a[3]] = 64'h5003;
		walk(52'h5abc, 1'b0, 1'b1, 1'b0);
		i_mem.tbl[a[3]] = g[3];
		i_mem.tbl[a[2]] = 64'h0060_0087;
		walk(52'h604abc, 1'b0, 1'b1, 1'b1);
		i_mem.tbl[a[2]] = g[2];
		i_mem.tbl[a[1]] = 64'h4000_0087;
		walk(52'h40604abc, 1'b0, 1'b1, 1'b1);
		i_mem.tbl[a[1]] = g[1];
		// Each bad entry is patched in alone so the walk reaches it.
		for (int i = 0; i < 6; i++) begin
			i_mem.tbl[a[fi[i]]] = fv[i];
			walk(52'h0, 1'b1, 1'b0, 1'b0);
			i_mem.tbl[a[fi[i]]] = g[fi[i]];
		end
		final_report();
	end
endmodule : four_level_page_walker_test

// file: bench/pw_mem_model.sv
`timescale 1ns/1ps
// Answers each entry read after lat cycles; between answers the data lines churn.
module pw_mem_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic mem_rd_req,
	input wire logic [51:0] mem_rd_addr,
	input wire logic [3:0] lat,
	output logic mem_rd_valid,
	output logic [63:0] mem_rd_data,
	output logic [7:0] reads
);
	logic [63:0] tbl [logic [51:0]];
	logic [51:0] addr_r;
	logic [3:0] wait_r;
	always_ff @(posedge clk) begin
		mem_rd_valid <= 1'b0;
		if (sys_rst) begin
			wait_r <= 4'h0;
			reads <= 8'h00;
			mem_rd_data <= 64'h0;
		end else if (mem_rd_req) begin
			addr_r <= mem_rd_addr;
			wait_r <= lat;
			reads <= reads + 8'h01;
			mem_rd_data <= ~mem_rd_data;
		end else if (wait_r == 4'h1) begin
			// A missing table slot reads as a not-present entry.
			mem_rd_valid <= 1'b1;
			mem_rd_data <= tbl.exists(addr_r) ? tbl[addr_r] : 64'h0;
			wait_r <= 4'h0;
		end else begin
			if (wait_r > 4'h1) wait_r <= wait_r - 4'h1;
			mem_rd_data <= ~mem_rd_data;
		end
	end
endmodule : pw_mem_model

// file: verilog/pw_walker.sv
`timescale 1ns/1ps
`include "pw_walker_map.svh"
// Notes on behaviour
// - Translate only with all three enables set.
// - 48-bit linear in, 52-bit physical out.
// - Tag off: root bits 4:3 give attributes.
// - Tag on: root bits 11:0 hold tag.
// - Tag enable change: top read attributes follow at once, tag output a cycle later.
// - Physical bits above width always zero.
// - Top entry address from root and 47:39.
// - Third entry address from top and 38:30.
// - Third entry with size flag: 1G page.
// - Otherwise fetch directory entry using 29:21.
// - Directory entry with size flag: 2M page.
// - Otherwise fetch leaf entry using 20:12.
// - Leaf entry always maps a 4K page.
// - Not present or reserved bit faults.
// - Bits above physical width are reserved.
// - Size flag reserved in top entry.
// - Without 1G support third size flag reserved.
// - Large-page low address bits are reserved.
// - No-exec flag reserved while no-exec disabled.
// - Rights failure only clears rights_ok; the address is still returned.
module pw_walker #(
	parameter int PA_W = `PW_PHYS_W,
	parameter bit GB_PAGES = 1'b1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic paging_enable,
	input wire logic address_extension_enable,
	input wire logic long_mode_enable,
	input wire logic no_exec_enable,
	input wire logic context_tag_enable,
	input wire logic root_wr_en,
	input wire logic [63:0] root_wr_data,
	output logic [63:0] root_rd_data,
	output logic [`PW_TAG_W-1:0] context_tag,
	input wire logic req_valid,
	input wire pw_walker_pkg::pw_req_t req,
	output logic req_ready,
	output logic done,
	output pw_walker_pkg::pw_rsp_t rsp,
	output logic mem_rd_req,
	output logic [`PW_PHYS_W-1:0] mem_rd_addr,
	output logic [1:0] mem_rd_attr,
	input wire logic mem_rd_valid,
	input wire logic [63:0] mem_rd_data
);
	import pw_walker_pkg::*;

	if (PA_W < 32 || PA_W > `PW_PHYS_W) begin : g_bad_width
		$error("pw_walker: PA_W must lie between 32 and 52");
	end

	// Mask of implemented physical bits; the rest must stay zero everywhere.
	localparam logic [51:0] PA_MASK = ~(52'hf_ffff_ffff_ffff << PA_W);

	pw_state_t state_r;
	pw_level_t lvl_r;
	pw_req_t req_r;
	logic [63:0] root_r;
	logic rw_all_r, us_all_r, xd_any_r;
	logic go, walk_on, bad, ps, leaf_now, rights_now;
	logic [51:0] final_phys;
	pw_page_t final_page;
	logic [8:0] next_idx;
	logic [51:0] next_addr;

	assign go = (state_r == PW_IDLE) && req_valid;
	assign walk_on = paging_enable && address_extension_enable && long_mode_enable;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			root_r <= `PW_ROOT_RST;
		end else if (root_wr_en) begin
			root_r <= root_wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			root_rd_data <= `PW_ROOT_RST;
			context_tag <= '0;
		end else begin
			root_rd_data <= root_r;
			// The tag follows the enable one clock later, so a cleared enable shows tag zero.
			context_tag <= context_tag_enable ? root_r[`PW_ROOT_TAG_HI:0] : '0;
		end
	end

	// Entry checks for the level currently being answered.
	always_comb begin
		ps = mem_rd_data[`PW_PS_BIT];
		bad = !mem_rd_data[`PW_P_BIT];
		if ((mem_rd_data[51:0] & ~PA_MASK) != 52'h0) begin
			bad = 1'b1;
		end
		if (!no_exec_enable && mem_rd_data[`PW_XD_BIT]) begin
			bad = 1'b1;
		end
		if (lvl_r == PW_LVL_TOP && ps) begin
			bad = 1'b1;
		end
		if (lvl_r == PW_LVL_THIRD && ps) begin
			if (!GB_PAGES) begin
				bad = 1'b1;
			end
			if (mem_rd_data[`PW_GB_RSV_HI:`PW_RSV_LO] != 17'h0) begin
				bad = 1'b1;
			end
		end
		if (lvl_r == PW_LVL_DIR && ps && mem_rd_data[`PW_MB_RSV_HI:`PW_RSV_LO] != 8'h0) begin
			bad = 1'b1;
		end
		leaf_now = (lvl_r == PW_LVL_LEAF) || (lvl_r != PW_LVL_TOP && ps);
	end

	// Final address and page size when this entry maps the page.
	always_comb begin
		if (lvl_r == PW_LVL_THIRD) begin
			final_page = PW_PG_1G;
			final_phys = {mem_rd_data[51:30], req_r.lin[29:0]} & PA_MASK;
		end else if (lvl_r == PW_LVL_DIR) begin
			final_page = PW_PG_2M;
			final_phys = {mem_rd_data[51:21], req_r.lin[20:0]} & PA_MASK;
		end else begin
			final_page = PW_PG_4K;
			final_phys = {mem_rd_data[51:12], req_r.lin[11:0]} & PA_MASK;
		end
	end

	// Address of the next entry below the one now answered.
	always_comb begin
		if (lvl_r == PW_LVL_TOP) begin
			next_idx = req_r.lin[38:30];
		end else if (lvl_r == PW_LVL_THIRD) begin
			next_idx = req_r.lin[29:21];
		end else begin
			next_idx = req_r.lin[20:12];
		end
		next_addr = {mem_rd_data[51:12], next_idx, 3'b000} & PA_MASK;
	end

	// Rights of the whole walk including the entry now answered.
	always_comb begin
		rights_now = 1'b1;
		if (req_r.is_write && !(rw_all_r && mem_rd_data[`PW_RW_BIT])) begin
			rights_now = 1'b0;
		end
		if (req_r.is_user && !(us_all_r && mem_rd_data[`PW_US_BIT])) begin
			rights_now = 1'b0;
		end
		if (req_r.is_fetch && no_exec_enable && (xd_any_r || mem_rd_data[`PW_XD_BIT])) begin
			rights_now = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			req_r <= '0;
		end else if (go) begin
			req_r <= req;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rw_all_r <= 1'b1;
			us_all_r <= 1'b1;
			xd_any_r <= 1'b0;
		end else if (go) begin
			rw_all_r <= 1'b1;
			us_all_r <= 1'b1;
			xd_any_r <= 1'b0;
		end else if (state_r == PW_WAIT && mem_rd_valid) begin
			rw_all_r <= rw_all_r && mem_rd_data[`PW_RW_BIT];
			us_all_r <= us_all_r && mem_rd_data[`PW_US_BIT];
			xd_any_r <= xd_any_r || mem_rd_data[`PW_XD_BIT];
		end
	end

	// Walk sequencer: one outstanding read, answered before the next is issued.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= PW_IDLE;
			lvl_r <= PW_LVL_TOP;
		end else begin
			case (state_r)
				PW_IDLE: begin
					if (go && walk_on) begin
						state_r <= PW_WAIT;
						lvl_r <= PW_LVL_TOP;
					end
				end
				PW_WAIT: begin
					if (mem_rd_valid) begin
						if (bad || leaf_now) begin
							state_r <= PW_IDLE;
						end else begin
							lvl_r <= pw_level_t'(lvl_r - 2'd1);
						end
					end
				end
				default: begin
					state_r <= PW_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			req_ready <= 1'b0;
		end else begin
			req_ready <= (state_r == PW_IDLE) && !go;
		end
	end

	// Top-table reads carry root attributes only while tagging is off.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mem_rd_req <= 1'b0;
			mem_rd_addr <= '0;
			mem_rd_attr <= 2'b00;
		end else begin
			mem_rd_req <= 1'b0;
			if (go && walk_on) begin
				mem_rd_req <= 1'b1;
				mem_rd_addr <= {root_r[51:12], req.lin[47:39], 3'b000} & PA_MASK;
				if (context_tag_enable) begin
					mem_rd_attr <= 2'b00;
				end else begin
					mem_rd_attr <= {root_r[`PW_ROOT_PCD_BIT], root_r[`PW_ROOT_PWT_BIT]};
				end
			end else if (state_r == PW_WAIT && mem_rd_valid && !bad && !leaf_now) begin
				mem_rd_req <= 1'b1;
				mem_rd_addr <= next_addr;
				mem_rd_attr <= 2'b00;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			done <= 1'b0;
			rsp <= '0;
		end else begin
			done <= 1'b0;
			if (go && !walk_on) begin
				// Untranslated addresses pass through, cut to the physical width.
				done <= 1'b1;
				rsp.phys <= {4'h0, req.lin} & PA_MASK;
				rsp.translated <= 1'b0;
				rsp.fault <= 1'b0;
				rsp.page <= PW_PG_4K;
				rsp.rights_ok <= 1'b1;
			end else if (state_r == PW_WAIT && mem_rd_valid && (bad || leaf_now)) begin
				done <= 1'b1;
				rsp.translated <= 1'b1;
				rsp.fault <= bad;
				rsp.page <= final_page;
				rsp.phys <= bad ? 52'h0 : final_phys;
				rsp.rights_ok <= !bad && rights_now;
			end
		end
	end

	// Assertions.
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	read_pulse_a: assert property (mem_rd_req |=> !mem_rd_req)
		else $error("memory read request held longer than one cycle");
	top_addr_a: assert property (go && walk_on |=> mem_rd_req &&
		mem_rd_addr[11:3] == $past(req.lin[47:39]) &&
		mem_rd_addr[51:12] == ($past(root_r[51:12]) & PA_MASK[51:12]))
		else $error("top entry address wrong");
	phys_zero_a: assert property (done |-> (rsp.phys & ~PA_MASK) == 52'h0 &&
		(mem_rd_addr & ~PA_MASK) == 52'h0)
		else $error("physical bits above width not zero");
	gb_offset_a: assert property (done && rsp.translated && !rsp.fault && rsp.page == PW_PG_1G
		|-> rsp.phys[29:0] == req_r.lin[29:0])
		else $error("1G page offset wrong");
	mb_offset_a: assert property (done && rsp.translated && !rsp.fault && rsp.page == PW_PG_2M
		|-> rsp.phys[20:0] == req_r.lin[20:0])
		else $error("2M page offset wrong");
	kb_offset_a: assert property (done && rsp.translated && !rsp.fault && rsp.page == PW_PG_4K
		|-> rsp.phys[11:0] == req_r.lin[11:0])
		else $error("4K page offset wrong");
	absent_fault_a: assert property (state_r == PW_WAIT && mem_rd_valid && !mem_rd_data[0]
		|=> done && rsp.fault && !mem_rd_req)
		else $error("absent entry did not fault");
	noexec_rsv_a: assert property (state_r == PW_WAIT && mem_rd_valid && !no_exec_enable &&
		mem_rd_data[`PW_XD_BIT] |=> done && rsp.fault)
		else $error("no-exec flag not treated as reserved");
	top_size_a: assert property (state_r == PW_WAIT && lvl_r == PW_LVL_TOP && mem_rd_valid &&
		mem_rd_data[`PW_PS_BIT] |=> done && rsp.fault)
		else $error("size flag in top entry accepted");
	tag_clear_a: assert property (!context_tag_enable |=> context_tag == '0)
		else $error("context tag not zero with tagging off");
	off_pass_a: assert property (go && !walk_on |=> done && !rsp.translated && !mem_rd_req)
		else $error("walk started with translation disabled");
	fault_rights_a: assert property (done && rsp.fault |-> !rsp.rights_ok)
		else $error("faulted walk reported usable rights");

	// Address bits above the implemented width must stop the walk at any level.
	reserved_high_a: assert property (state_r == PW_WAIT && mem_rd_valid &&
		(mem_rd_data[51:0] & ~PA_MASK) != 52'h0 |=> done && rsp.fault)
		else $error("entry with bits above physical width accepted");

	// Large-page entries must keep their unused low address bits clear.
	gb_reserved_a: assert property (state_r == PW_WAIT && lvl_r == PW_LVL_THIRD &&
		mem_rd_valid && mem_rd_data[`PW_PS_BIT] &&
		mem_rd_data[`PW_GB_RSV_HI:`PW_RSV_LO] != 17'h0 |=> done && rsp.fault)
		else $error("1G entry with reserved low bits accepted");
	mb_reserved_a: assert property (state_r == PW_WAIT && lvl_r == PW_LVL_DIR &&
		mem_rd_valid && mem_rd_data[`PW_PS_BIT] &&
		mem_rd_data[`PW_MB_RSV_HI:`PW_RSV_LO] != 8'h0 |=> done && rsp.fault)
		else $error("2M entry with reserved low bits accepted");

	// Only meaningful for a build without large third-level pages.
	gb_support_a: assert property (state_r == PW_WAIT && lvl_r == PW_LVL_THIRD &&
		mem_rd_valid && mem_rd_data[`PW_PS_BIT] && !GB_PAGES |=> done && rsp.fault)
		else $error("1G page used without support");

	// Attributes of the top read follow the tag enable of the same cycle.
	top_attr_a: assert property (go && walk_on && !context_tag_enable |=>
		mem_rd_attr == $past({root_r[`PW_ROOT_PCD_BIT], root_r[`PW_ROOT_PWT_BIT]}))
		else $error("top read attributes not taken from root");
	tag_attr_a: assert property (go && walk_on && context_tag_enable |=>
		mem_rd_attr == 2'b00)
		else $error("top read attributes used while tagging is on");

	// A good table entry must lead to exactly one further read and no completion.
	next_read_a: assert property (state_r == PW_WAIT && mem_rd_valid && !bad && !leaf_now
		|=> mem_rd_req && !done)
		else $error("walk did not continue to the next level");

	walk_4k_c: cover property (done && rsp.translated && !rsp.fault && rsp.page == PW_PG_4K);
	walk_2m_c: cover property (done && rsp.translated && !rsp.fault && rsp.page == PW_PG_2M);
	walk_1g_c: cover property (done && rsp.translated && !rsp.fault && rsp.page == PW_PG_1G);
	walk_fault_c: cover property (done && rsp.fault);
	walk_off_c: cover property (done && !rsp.translated);

endmodule : pw_walker

// file: verilog/pw_walker_map.svh
`ifndef PW_WALKER_MAP_SVH
`define PW_WALKER_MAP_SVH

// Entry field positions.
`define PW_P_BIT 0
`define PW_RW_BIT 1
`define PW_US_BIT 2
`define PW_PS_BIT 7
`define PW_XD_BIT 63

// Root register fields.
`define PW_ROOT_PWT_BIT 3
`define PW_ROOT_PCD_BIT 4
`define PW_ROOT_TAG_HI 11
`define PW_ROOT_BASE_LO 12
`define PW_ROOT_RST 64'h0

// Reserved ranges of large-page entries.
`define PW_GB_RSV_HI 29
`define PW_MB_RSV_HI 20
`define PW_RSV_LO 13

// Documented widths.
`define PW_LIN_W 48
`define PW_PHYS_W 52
`define PW_TAG_W 12

`endif

// file: verilog/pw_walker_pkg.sv
package pw_walker_pkg;

	typedef enum logic [1:0] {
		PW_IDLE = 2'b00,
		PW_WAIT = 2'b01
	} pw_state_t;

	typedef enum logic [1:0] {
		PW_LVL_LEAF = 2'b00,
		PW_LVL_DIR = 2'b01,
		PW_LVL_THIRD = 2'b10,
		PW_LVL_TOP = 2'b11
	} pw_level_t;

	typedef enum logic [1:0] {
		PW_PG_4K = 2'b00,
		PW_PG_2M = 2'b01,
		PW_PG_1G = 2'b10
	} pw_page_t;

	typedef struct packed {
		logic [47:0] lin;
		logic is_write;
		logic is_user;
		logic is_fetch;
	} pw_req_t;

	typedef struct packed {
		logic [51:0] phys;
		logic translated;
		logic fault;
		pw_page_t page;
		logic rights_ok;
	} pw_rsp_t;

endpackage : pw_walker_pkg
